// File: flash_rom_protection_regs.sv
`timescale 1ns/100ps
// Functional notes
// [R1] Security register at 0x10, control status at 0x20, others reserved.
// [R2] Software never touches reserved offsets.
// [R3] Six read-only block protection bits at 21-16; protected blocks refuse writes.
// [R4] Bit 0 ready flag: 0 busy, 1 done; resets to 1.
// [R5] Failed operation holds ready at 0 until hardware reset.
// [R6] Host issues commands only when ready.
// [R7] Lockout recovery needs reset of 0.5 ms; reads after 2 ms.
// [R8] Security register set only by cold reset; bit 0 read/write, rest zero.
// [R9] Security enable is 1 after power-on reset.
// [R10] Software writes key first to change security bit.
// [R11] Data write accepted only within 16 clocks after key.
// [R12] Key and data must both be 32-bit transfers.
// [R13] Protection bits programmed one block at a time.
// [R14] Erase with security 1 and all bits set clears all bits; code erases on prot_erase_in with mode_ok_in alone.
// [R15] Protection write and erase allowed in chip, boot, writer modes.
// [R16] Protection bits change by command sequence only; rst_b_in reset also clears them.
// [R17] Security active only with enable 1 and all blocks protected.
// [R18] Active security blocks debug, trace and flash command writes.
// [R19] Programming bit to 1 protects block; 0 cancels. Code programming only sets a bit; only erase or rst_b_in clears bits.
// [R20] Reserved bits read zero and ignore writes.
// [R21] Late data or wrong key abandons unlock, bit unchanged.
module flash_rom_protection_regs
   import protection_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic cold_rst_b_in,
   input wire logic [11:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic word_access_in,
   output logic [31:0] rdata_out,
   input wire logic op_start_in,
   input wire logic op_done_in,
   input wire logic op_fail_in,
   input wire logic prot_prog_in,
   input wire logic [2:0] prot_blk_in,
   input wire logic prot_erase_in,
   input wire logic mode_ok_in,
   input wire logic [5:0] write_blk_sel_in,
   output logic write_refuse_out,
   output logic security_active_out,
   output logic debug_block_out,
   output logic cmd_block_out
);
   // ********************************
   // Unlock sequencer
   // ********************************
   typedef enum logic [0:0] {idle_st = 1'b0, armed_st = 1'b1} unlock_type;
   unlock_type unlock_ff;
   logic [4:0] win_ff;
   logic sec_ff;
   logic ready_ff;
   logic failed_ff;
   logic sec_wr;
   prot_bits_if pb ();

   // Matches a bus address against one register offset.
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
      reg_hit = a == off;
   endfunction : reg_hit

   // [R1] Register decode.
   assign sec_wr = wr_in && reg_hit(addr_in, sec_reg_off);

   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         unlock_ff <= idle_st;
         win_ff <= 5'h00;
      end
      else
      begin
         unique case (unlock_ff)
            idle_st:
            begin
               // [R12] Word key only.
               if (sec_wr && word_access_in && wdata_in == unlock_key)
               begin
                  unlock_ff <= armed_st;
                  win_ff <= 5'h00;
               end
            end
            armed_st:
            begin
               win_ff <= win_ff + 5'h01;
               // [R21] Window expiry abandons.
               if (sec_wr || win_ff >= 5'(unlock_window_clks - 1))
               begin
                  unlock_ff <= idle_st;
               end
            end
         endcase
      end
   end

   // ********************************
   // Security bit
   // ********************************
   always_ff @(posedge mclk_in)
   begin
      // [R9] Cold reset enables.
      if (!cold_rst_b_in)
      begin
         sec_ff <= sec_reset_val;
      end
      // [R11] Window data write.
      else if (unlock_ff == armed_st && sec_wr && word_access_in)
      begin
         // [R8] Bit zero only.
         sec_ff <= wdata_in[sec_pos];
      end
   end

   // ********************************
   // Ready flag
   // ********************************
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         // [R4] Ready after reset.
         ready_ff <= ready_reset_val;
         failed_ff <= 1'b0;
      end
      else if (op_fail_in || failed_ff)
      begin
         // [R5] Failure holds busy.
         failed_ff <= 1'b1;
         ready_ff <= 1'b0;
      end
      else if (op_start_in)
      begin
         ready_ff <= 1'b0;
      end
      else if (op_done_in)
      begin
         ready_ff <= 1'b1;
      end
   end

   // ********************************
   // Protection bits
   // ********************************
   // [R15] Mode gated programming.
   assign pb.prog_en = prot_prog_in && mode_ok_in && !cmd_block_out;
   assign pb.prog_blk = prot_blk_in;
   // [R14] Erase clears all.
   assign pb.erase_all = prot_erase_in && mode_ok_in;

   prot_bit_store u_store (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .pb(pb)
   );

   // [R17] Security activation.
   assign security_active_out = sec_ff && (&pb.bits);
   // [R18] Debug and command block.
   assign debug_block_out = security_active_out;
   assign cmd_block_out = security_active_out;
   // [R3] Protected block refusal.
   assign write_refuse_out = |(write_blk_sel_in & pb.bits);

   // ********************************
   // Read port
   // ********************************
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         rdata_out <= 32'h00000000;
      end
      else
      begin
         rdata_out <= 32'h00000000;
         if (rd_in)
         begin
            // [R20] Reserved read zero.
            if (reg_hit(addr_in, sec_reg_off))
            begin
               rdata_out[sec_pos] <= sec_ff;
            end
            else if (reg_hit(addr_in, ctl_reg_off))
            begin
               // [R3] Read-only status.
               rdata_out[blk_lsb +: block_count] <= pb.bits;
               rdata_out[ready_pos] <= ready_ff;
            end
         end
      end
   end
endmodule : flash_rom_protection_regs

// File: flash_rom_protection_regs_assertions.sv
`timescale 1ns/100ps
module prot_regs_checker
   import protection_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [11:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic word_access_in,
   input wire logic [31:0] rdata_out,
   input wire logic op_start_in,
   input wire logic op_done_in,
   input wire logic prot_prog_in,
   input wire logic prot_erase_in,
   input wire logic [5:0] write_blk_sel_in,
   input wire logic write_refuse_out,
   input wire logic security_active_out,
   input wire logic debug_block_out,
   input wire logic cmd_block_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_rd(a); rd_in && addr_in == a; endsequence
   sequence s_sw(d); wr_in && word_access_in && addr_in == sec_reg_off && d; endsequence
   property p_idle; !rd_in |=> rdata_out == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_resv; rd_in && addr_in != sec_reg_off && addr_in != ctl_reg_off |=> !rdata_out; endproperty
   a_resv: assert property (p_resv) else $error("reserved read not zero");
   property p_ctl; s_rd(ctl_reg_off) |=> !rdata_out[31:22] && !rdata_out[15:1]; endproperty
   a_ctl: assert property (p_ctl) else $error("status spare bits set");
   property p_sec; s_rd(sec_reg_off) |=> rdata_out[31:1] == 31'h0; endproperty
   a_sec: assert property (p_sec) else $error("security spare bits set");
   property p_busy; op_start_in && !op_done_in ##1 !op_done_in ##1 s_rd(ctl_reg_off) |=> !rdata_out[0]; endproperty
   a_busy: assert property (p_busy) else $error("ready during operation");
   property p_refuse; s_rd(ctl_reg_off) && !prot_prog_in && !prot_erase_in |=> write_refuse_out == |(rdata_out[21:16] & write_blk_sel_in); endproperty
   a_refuse: assert property (p_refuse) else $error("write refuse wrong");
   property p_block; security_active_out |-> debug_block_out && cmd_block_out; endproperty
   a_block: assert property (p_block) else $error("debug or command not blocked");
   property p_unlock; s_sw(wdata_in == unlock_key) ##2 s_sw(wdata_in != unlock_key) ##2 s_rd(sec_reg_off) |=> rdata_out[0] == $past(wdata_in[0], 3); endproperty
   a_unlock: assert property (p_unlock) else $error("unlocked write lost");
endmodule : prot_regs_checker
bind flash_rom_protection_regs prot_regs_checker chk (.*);

// File: flash_rom_protection_regs_tb.sv
`timescale 1ns/100ps
module flash_rom_protection_regs_tb
   import protection_pkg::*;
;
   logic mclk_in = 0, rst_b_in = 0, cold_rst_b_in = 0, wr_in = 0, rd_in = 0, word_access_in = 1;
   logic op_start_in = 0, op_done_in = 0, op_fail_in = 0, prot_prog_in = 0, prot_erase_in = 0;
   logic mode_ok_in = 1, write_refuse_out, security_active_out, debug_block_out, cmd_block_out;
   logic [11:0] addr_in = 0;
   logic [31:0] wdata_in = 0, rdata_out, v;
   logic [2:0] prot_blk_in = 0;
   logic [5:0] write_blk_sel_in = 0;
   int mismatches = 0, checks = 0, cyc = 0;
   flash_rom_protection_regs uut (.*);
   always #2 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         results();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d, input logic w);
      @(posedge mclk_in);
      {wr_in, addr_in, wdata_in, word_access_in} <= {1'b1, a, d, w};
      @(posedge mclk_in);
      wr_in <= 0;
   endtask : wr
   task rd(input logic [11:0] a);
      @(posedge mclk_in);
      {rd_in, addr_in} <= {1'b1, a};
      @(posedge mclk_in);
      rd_in <= 0;
      #1;
      v = rdata_out;
   endtask : rd
   task pulse(input logic [4:0] p);
      @(posedge mclk_in);
      {op_start_in, op_done_in, op_fail_in, prot_erase_in, prot_prog_in} <= p;
      @(posedge mclk_in);
      {op_start_in, op_done_in, op_fail_in, prot_erase_in, prot_prog_in} <= 5'h00;
   endtask : pulse
   task t_regs;
      rd(ctl_reg_off);
      chk(v, 32'h1);
      rd(sec_reg_off);
      chk(v, 32'h1);
      rd(12'h030);
      chk(v, 32'h0);
      wr(ctl_reg_off, 32'hffffffff, 1);
      rd(ctl_reg_off);
      chk(v, 32'h1);
      wr(sec_reg_off, unlock_key, 1);
      wr(sec_reg_off, 32'h0, 1);
      rd(sec_reg_off);
      chk(v, 32'h0);
      wr(sec_reg_off, unlock_key, 0);
      wr(sec_reg_off, 32'h1, 1);
      rd(sec_reg_off);
      chk(v, 32'h0);
      wr(sec_reg_off, unlock_key, 1);
      repeat (16) @(posedge mclk_in);
      wr(sec_reg_off, 32'h1, 1);
      wr(sec_reg_off, 32'h1, 1);
      rd(sec_reg_off);
      chk(v, 32'h0);
      $display("registers done");
   endtask : t_regs
   task t_busy;
      pulse(5'h10);
      rd(ctl_reg_off);
      chk(v, 32'h0);
      pulse(5'h08);
      rd(ctl_reg_off);
      chk(v, 32'h1);
      pulse(5'h04);
      pulse(5'h08);
      rd(ctl_reg_off);
      chk(v, 32'h0);
      rst_b_in <= 0;
      @(posedge mclk_in);
      rst_b_in <= 1;
      rd(ctl_reg_off);
      chk(v, 32'h1);
      rd(sec_reg_off);
      chk(v, 32'h0);
      $display("busy done");
   endtask : t_busy
   task t_prot;
      mode_ok_in <= 0;
      prot_blk_in <= 3'h0;
      pulse(5'h01);
      rd(ctl_reg_off);
      chk(v, 32'h1);
      mode_ok_in <= 1;
      for (int i = 0; i < 6; i++)
      begin
         prot_blk_in <= i[2:0];
         write_blk_sel_in <= 6'h01 << i;
         pulse(5'h01);
         rd(ctl_reg_off);
         chk(v, (32'h1 << (i + 17)) - 32'hffff);
         chk({31'h0, write_refuse_out}, 32'h1);
      end
      chk({31'h0, security_active_out}, 32'h0);
      wr(sec_reg_off, unlock_key, 1);
      wr(sec_reg_off, 32'h1, 1);
      rd(sec_reg_off);
      chk({29'h0, security_active_out, debug_block_out, cmd_block_out}, 32'h7);
      pulse(5'h02);
      rd(ctl_reg_off);
      chk(v, 32'h1);
      $display("protection done");
   endtask : t_prot
   task results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   initial
   begin
      repeat (20) @(posedge mclk_in);
      {rst_b_in, cold_rst_b_in} <= 2'h3;
      t_regs();
      t_busy();
      t_prot();
      results();
   end
endmodule : flash_rom_protection_regs_tb

// File: prot_bit_store.sv
`timescale 1ns/100ps
module prot_bit_store
   import protection_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   prot_bits_if.store pb
);
   logic [5:0] bits_ff;
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         bits_ff <= blk_reset_val;
      end
      else if (pb.erase_all)
      begin
         bits_ff <= 6'h00;
      end
      // [R13] One block only.
      else if (pb.prog_en && pb.prog_blk < 3'h6)
      begin
         // [R19] Set protects block.
         bits_ff[pb.prog_blk] <= 1'b1;
      end
   end
   assign pb.bits = bits_ff;
endmodule : prot_bit_store

// File: prot_bits_if.sv
`timescale 1ns/100ps
interface prot_bits_if;
   logic prog_en;
   logic [2:0] prog_blk;
   logic erase_all;
   logic [5:0] bits;
   modport store (input prog_en, input prog_blk, input erase_all, output bits);
   modport ctrl (output prog_en, output prog_blk, output erase_all, input bits);
endinterface : prot_bits_if

// File: protection_pkg.sv
package protection_pkg;
   localparam logic [11:0] sec_reg_off = 12'h010;
   localparam logic [11:0] ctl_reg_off = 12'h020;
   localparam logic [31:0] unlock_key = 32'ha74a9d23;
   localparam int unlock_window_clks = 16;
   localparam int block_count = 6;
   localparam int blk_lsb = 16;
   localparam int ready_pos = 0;
   localparam int sec_pos = 0;
   localparam logic sec_reset_val = 1'b1;
   localparam logic ready_reset_val = 1'b1;
   localparam logic [5:0] blk_reset_val = 6'h00;
endpackage : protection_pkg
